// [inc/icp_pkg.sv]
// Purpose: Constants for the interrupt control and power mode block
// Assumes: Nibble-wide control locations reached by bit manipulation
// Notes:   Flag, mask and mode encodings shared by design and bench
package icp_pkg;
   // Control nibble addresses
   localparam logic [1:0] ICP_ADDR_N0 = 2'h0;
   localparam logic [1:0] ICP_ADDR_N1 = 2'h1;
   localparam logic [1:0] ICP_ADDR_N2 = 2'h2;
   localparam logic [1:0] ICP_ADDR_N3 = 2'h3;
   // Bit positions inside the nibbles
   localparam int ICP_B_IE    = 0;   // Nibble 0
   localparam int ICP_B_N0_IF = 1;   // Nibble 0 ext0 flag
   localparam int ICP_B_N0_IM = 2;   // Nibble 0 ext0 mask
   localparam int ICP_B_N1_IF = 0;   // Nibble 1 ext1 flag
   localparam int ICP_B_N1_IM = 1;   // Nibble 1 ext1 mask
   localparam int ICP_B_TF    = 2;   // Nibble 1/2 timer flag
   localparam int ICP_B_TM    = 3;   // Nibble 1/2 timer mask
   localparam int ICP_B_T3F   = 0;   // Nibble 3
   localparam int ICP_B_T3M   = 1;
   localparam int ICP_B_SF    = 2;
   localparam int ICP_B_SM    = 3;
   // Source indices in priority order, highest first
   localparam int ICP_NSRC = 6;
   localparam int ICP_S_EXT0 = 0;
   localparam int ICP_S_EXT1 = 1;
   localparam int ICP_S_TMR1 = 2;
   localparam int ICP_S_TMR2 = 3;
   localparam int ICP_S_TMR3 = 4;
   localparam int ICP_S_SER  = 5;
   // Reset values
   localparam logic [ICP_NSRC-1:0] ICP_FLAG_RST = 6'h00;
   localparam logic [ICP_NSRC-1:0] ICP_MASK_RST = 6'h3F;
   localparam logic [3:0] ICP_NIB_ZERO = 4'h0;
   // Vector addresses per source
   localparam logic [15:0] ICP_VEC_NONE = 16'h0000;
   localparam logic [15:0] ICP_VEC_EXT0 = 16'h0002;
   localparam logic [15:0] ICP_VEC_EXT1 = 16'h0004;
   localparam logic [15:0] ICP_VEC_TMR1 = 16'h0006;
   localparam logic [15:0] ICP_VEC_TMR2 = 16'h000A;
   localparam logic [15:0] ICP_VEC_TMR3 = 16'h000C;
   localparam logic [15:0] ICP_VEC_SER  = 16'h000E;
   // Power modes
   typedef enum logic [1:0] {ICP_ACTIVE, ICP_STANDBY, ICP_STOP} icp_mode_t;
endpackage

// [rtl/icp_irq_power.sv]
// Purpose: Interrupt flags, masks, global enable, priority vector and
//          standby/stop mode control of a small nibble-wide controller
// Assumes: CPU strobes are one-cycle pulses synchronous to clk
// Notes:   Flags are set by hardware only; software may clear them
`timescale 1ns/10ps
module icp_irq_power
   import icp_pkg::*;
(
   input  wire logic        clk,               // System clock
   input  wire logic        rst_b,             // Asynchronous reset, active low
   input  wire logic        ext_irq_in_0,      // External request 0, active low
   input  wire logic        ext_irq_in_1,      // External request 1, active low
   input  wire logic        timer1_ovf,        // Timer one overflow pulse
   input  wire logic        timer2_ovf,        // Timer two overflow pulse
   input  wire logic        timer3_ovf,        // Timer three overflow pulse
   input  wire logic        capture_en,        // Input capture in use
   input  wire logic        capture_rise,      // Capture edge: 1 rising, 0 falling
   input  wire logic        event_count_input, // Event count input level
   input  wire logic        serial_done,       // Serial transfer complete pulse
   input  wire logic        serial_susp,       // Serial transfer suspended pulse
   input  wire logic [1:0]  nib_addr,          // Control nibble address
   input  wire logic        nib_wr,            // Nibble write strobe
   input  wire logic [3:0]  nib_wdata,         // Nibble write data
   output logic      [3:0]  nib_rdata,         // Nibble read data
   input  wire logic        irq_ack,           // CPU accepts the interrupt
   input  wire logic        return_from_irq_instr, // Return instruction executes
   input  wire logic        standby_instr,     // Standby instruction executes
   input  wire logic        stop_instr,        // Stop instruction executes
   input  wire logic        stop_cancel_input, // Stop cancel, active high
   output logic             irq_req,           // Serviceable request to CPU
   output logic      [15:0] irq_vector,        // Vector of the winning source
   output logic             cpu_halt,          // CPU clocks held
   output logic             osc_stop,          // Oscillator halted
   output logic             periph_reset,      // Timers, serial, comparator reset
   output logic             comparator_stop,   // Comparator stopped
   output logic             pin_out_en,        // Output pins enabled, low in stop
   output logic             ram_valid_flag     // Set when stop left by cancel
);

   logic                global_irq_enable_r;
   logic [ICP_NSRC-1:0] flag_r;
   logic [ICP_NSRC-1:0] mask_r;
   logic [ICP_NSRC-1:0] set_ev;
   logic [ICP_NSRC-1:0] clr_ev;
   logic [ICP_NSRC-1:0] pend;
   logic [ICP_NSRC-1:0] wr_mask_sel;
   logic [ICP_NSRC-1:0] wr_mask_val;
   logic                ext0_d_r;
   logic                ext1_d_r;
   logic                evt_d_r;
   logic                edges_ok_r;
   icp_mode_t           mode_r;
   logic                any_pend;
   logic                ram_valid_flag_r;

   // Previous levels for edge detection; edges_ok avoids a false edge after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext0_d_r   <= 1'b1;
         ext1_d_r   <= 1'b1;
         evt_d_r    <= 1'b0;
         edges_ok_r <= 1'b0;
      end else begin
         ext0_d_r   <= ext_irq_in_0;
         ext1_d_r   <= ext_irq_in_1;
         evt_d_r    <= event_count_input;
         edges_ok_r <= 1'b1;
      end
   end

   // Hardware set events per source
   always_comb begin
      set_ev = '0;
      set_ev[ICP_S_EXT0] = edges_ok_r & ext0_d_r & ~ext_irq_in_0;
      set_ev[ICP_S_EXT1] = edges_ok_r & ext1_d_r & ~ext_irq_in_1;
      set_ev[ICP_S_TMR1] = timer1_ovf;
      set_ev[ICP_S_TMR2] = timer2_ovf;
      set_ev[ICP_S_TMR3] = timer3_ovf
                         | (capture_en & edges_ok_r &
                            (capture_rise ? (~evt_d_r & event_count_input)
                                          : (evt_d_r & ~event_count_input)));
      set_ev[ICP_S_SER]  = serial_done | serial_susp;
   end

   // Decode software writes into per-source flag clears and mask writes
   always_comb begin
      clr_ev      = '0;
      wr_mask_sel = '0;
      wr_mask_val = '0;
      if (nib_wr) begin
         case (nib_addr)
            ICP_ADDR_N0: begin
               clr_ev[ICP_S_EXT0]      = ~nib_wdata[ICP_B_N0_IF];
               wr_mask_sel[ICP_S_EXT0] = 1'b1;
               wr_mask_val[ICP_S_EXT0] = nib_wdata[ICP_B_N0_IM];
            end
            ICP_ADDR_N1: begin
               clr_ev[ICP_S_EXT1]      = ~nib_wdata[ICP_B_N1_IF];
               wr_mask_sel[ICP_S_EXT1] = 1'b1;
               wr_mask_val[ICP_S_EXT1] = nib_wdata[ICP_B_N1_IM];
               clr_ev[ICP_S_TMR1]      = ~nib_wdata[ICP_B_TF];
               wr_mask_sel[ICP_S_TMR1] = 1'b1;
               wr_mask_val[ICP_S_TMR1] = nib_wdata[ICP_B_TM];
            end
            ICP_ADDR_N2: begin
               clr_ev[ICP_S_TMR2]      = ~nib_wdata[ICP_B_TF];
               wr_mask_sel[ICP_S_TMR2] = 1'b1;
               wr_mask_val[ICP_S_TMR2] = nib_wdata[ICP_B_TM];
            end
            default: begin
               clr_ev[ICP_S_TMR3]      = ~nib_wdata[ICP_B_T3F];
               wr_mask_sel[ICP_S_TMR3] = 1'b1;
               wr_mask_val[ICP_S_TMR3] = nib_wdata[ICP_B_T3M];
               clr_ev[ICP_S_SER]       = ~nib_wdata[ICP_B_SF];
               wr_mask_sel[ICP_S_SER]  = 1'b1;
               wr_mask_val[ICP_S_SER]  = nib_wdata[ICP_B_SM];
            end
         endcase
      end
   end

   // Per-source flag and mask; stop mode resets the peripherals, not these bits
   genvar gi;
   generate
      for (gi = 0; gi < ICP_NSRC; gi = gi + 1) begin : g_src
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               flag_r[gi] <= ICP_FLAG_RST[gi];
               mask_r[gi] <= ICP_MASK_RST[gi];
            end else begin
               if (set_ev[gi]) begin
                  flag_r[gi] <= 1'b1;
               end else if (clr_ev[gi]) begin
                  flag_r[gi] <= 1'b0;
               end
               if (wr_mask_sel[gi]) begin
                  mask_r[gi] <= wr_mask_val[gi];
               end
            end
         end
      end
   endgenerate

   assign pend     = flag_r & ~mask_r;
   assign any_pend = |pend;

   // Global enable: accept clears it, return sets it, software writes bit 0
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         global_irq_enable_r <= 1'b0;
      end else if (irq_ack) begin
         global_irq_enable_r <= 1'b0;
      end else if (return_from_irq_instr) begin
         global_irq_enable_r <= 1'b1;
      end else if (nib_wr && nib_addr == ICP_ADDR_N0) begin
         global_irq_enable_r <= nib_wdata[ICP_B_IE];
      end
   end

   // request needs enable; fixed priority vector
   always_comb begin
      irq_req = global_irq_enable_r & any_pend & (mode_r == ICP_ACTIVE);
      if (pend[ICP_S_EXT0]) begin
         irq_vector = ICP_VEC_EXT0;
      end else if (pend[ICP_S_EXT1]) begin
         irq_vector = ICP_VEC_EXT1;
      end else if (pend[ICP_S_TMR1]) begin
         irq_vector = ICP_VEC_TMR1;
      end else if (pend[ICP_S_TMR2]) begin
         irq_vector = ICP_VEC_TMR2;
      end else if (pend[ICP_S_TMR3]) begin
         irq_vector = ICP_VEC_TMR3;
      end else if (pend[ICP_S_SER]) begin
         irq_vector = ICP_VEC_SER;
      end else begin
         irq_vector = ICP_VEC_NONE;
      end
   end

   // Read back; unused nibble bits read zero
   always_comb begin
      nib_rdata = ICP_NIB_ZERO;
      case (nib_addr)
         ICP_ADDR_N0: begin
            nib_rdata[ICP_B_IE]    = global_irq_enable_r;
            nib_rdata[ICP_B_N0_IF] = flag_r[ICP_S_EXT0];
            nib_rdata[ICP_B_N0_IM] = mask_r[ICP_S_EXT0];
         end
         ICP_ADDR_N1: begin
            nib_rdata[ICP_B_N1_IF] = flag_r[ICP_S_EXT1];
            nib_rdata[ICP_B_N1_IM] = mask_r[ICP_S_EXT1];
            nib_rdata[ICP_B_TF]    = flag_r[ICP_S_TMR1];
            nib_rdata[ICP_B_TM]    = mask_r[ICP_S_TMR1];
         end
         ICP_ADDR_N2: begin
            nib_rdata[ICP_B_TF]    = flag_r[ICP_S_TMR2];
            nib_rdata[ICP_B_TM]    = mask_r[ICP_S_TMR2];
         end
         default: begin
            nib_rdata[ICP_B_T3F]   = flag_r[ICP_S_TMR3];
            nib_rdata[ICP_B_T3M]   = mask_r[ICP_S_TMR3];
            nib_rdata[ICP_B_SF]    = flag_r[ICP_S_SER];
            nib_rdata[ICP_B_SM]    = mask_r[ICP_S_SER];
         end
      endcase
   end

   // Power mode machine; a pending unmasked request with enable clear turns
   // the low-power instruction into a no-op so the device cannot sleep forever
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= ICP_ACTIVE;
      end else begin
         case (mode_r)
            ICP_ACTIVE: begin
               if (!any_pend) begin
                  if (stop_instr) begin
                     mode_r <= ICP_STOP;
                  end else if (standby_instr) begin
                     mode_r <= ICP_STANDBY;
                  end
               end
            end
            ICP_STANDBY: begin
               if (any_pend) begin
                  mode_r <= ICP_ACTIVE;
               end
            end
            ICP_STOP: begin
               if (stop_cancel_input) begin
                  mode_r <= ICP_ACTIVE;
               end
            end
            default: begin
               mode_r <= ICP_ACTIVE;
            end
         endcase
      end
   end

   // Memory-valid flag shows whether stop was left by the cancel input
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ram_valid_flag_r <= 1'b0;
      end else if (mode_r == ICP_STOP && stop_cancel_input) begin
         ram_valid_flag_r <= 1'b1;
      end
   end

   // Mode outputs
   assign cpu_halt        = (mode_r != ICP_ACTIVE);
   assign osc_stop        = (mode_r == ICP_STOP);
   assign periph_reset    = (mode_r == ICP_STOP);
   assign comparator_stop = (mode_r != ICP_ACTIVE);
   assign pin_out_en      = (mode_r != ICP_STOP);
   assign ram_valid_flag  = ram_valid_flag_r;

   // Checks
   sequence s_stop_entry;
      (mode_r == ICP_ACTIVE) && stop_instr && !any_pend;
   endsequence

   chk_ext0_edge_sets: assert property (@(posedge clk) disable iff (!rst_b)
      edges_ok_r && ext0_d_r && !ext_irq_in_0 |=> flag_r[ICP_S_EXT0])
      else $error("ext0 falling edge did not set flag");
   chk_set_beats_clr: assert property (@(posedge clk) disable iff (!rst_b)
      set_ev[ICP_S_TMR1] && clr_ev[ICP_S_TMR1] |=> flag_r[ICP_S_TMR1])
      else $error("timer one flag lost to clear");
   chk_no_sw_set: assert property (@(posedge clk) disable iff (!rst_b)
      !flag_r[ICP_S_TMR1] && !set_ev[ICP_S_TMR1] |=> !flag_r[ICP_S_TMR1])
      else $error("timer one flag set without event");
   chk_ack_clears_en: assert property (@(posedge clk) disable iff (!rst_b)
      irq_ack |=> !global_irq_enable_r)
      else $error("enable not cleared on accept");
   chk_rti_sets_en: assert property (@(posedge clk) disable iff (!rst_b)
      return_from_irq_instr && !irq_ack |=> global_irq_enable_r)
      else $error("enable not set on return");
   chk_req_gating: assert property (@(posedge clk) disable iff (!rst_b)
      irq_req |-> global_irq_enable_r && |(flag_r & ~mask_r))
      else $error("request without enable and unmasked flag");
   chk_prio_ext0: assert property (@(posedge clk) disable iff (!rst_b)
      pend[ICP_S_EXT0] |-> irq_vector == ICP_VEC_EXT0)
      else $error("ext0 not highest priority");
   chk_stop_hiz: assert property (@(posedge clk) disable iff (!rst_b)
      s_stop_entry |=> !pin_out_en && osc_stop && periph_reset)
      else $error("stop entry did not release pins");
   chk_standby_wake: assert property (@(posedge clk) disable iff (!rst_b)
      (mode_r == ICP_STANDBY) && any_pend |=> !cpu_halt)
      else $error("standby not left on request");
   chk_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
      (mode_r == ICP_STOP) && !stop_cancel_input |=> osc_stop)
      else $error("stop left without cancel");

   // Low-power attempt; refused while any unmasked request is pending
   sequence s_sleep_try;
      (mode_r == ICP_ACTIVE) && (standby_instr || stop_instr);
   endsequence

   chk_sleep_refused: assert property (@(posedge clk) disable iff (!rst_b)
      s_sleep_try ##0 any_pend |=> !cpu_halt)
      else $error("low-power entry not refused with request pending");
   chk_standby_entry: assert property (@(posedge clk) disable iff (!rst_b)
      s_sleep_try ##0 (!stop_instr && !any_pend) |=> cpu_halt && !osc_stop && pin_out_en)
      else $error("standby not entered");
   chk_stop_cancel: assert property (@(posedge clk) disable iff (!rst_b)
      (mode_r == ICP_STOP) && stop_cancel_input |=> !osc_stop && ram_valid_flag)
      else $error("stop not left on cancel");
   chk_t2_ovf_sets: assert property (@(posedge clk) disable iff (!rst_b)
      timer2_ovf |=> flag_r[ICP_S_TMR2])
      else $error("timer two overflow did not set flag");
   chk_susp_sets: assert property (@(posedge clk) disable iff (!rst_b)
      serial_susp |=> flag_r[ICP_S_SER])
      else $error("serial suspend did not set flag");
   chk_cap_edge_sets: assert property (@(posedge clk) disable iff (!rst_b)
      capture_en && capture_rise && edges_ok_r && !evt_d_r && event_count_input
      |=> flag_r[ICP_S_TMR3])
      else $error("capture edge did not set timer three flag");

endmodule

// [tb/icp_cpu_model.sv]
// Purpose: CPU side model that accepts requests from the interrupt block
// Assumes: Request and vector are settled one step after a clock edge
// Notes:   Accept delay is set by the bench, zero answers at the next edge
`timescale 1ns/10ps
module icp_cpu_model
   import icp_pkg::*;
(
   input  wire logic        clk,       // System clock
   input  wire logic        rst_b,     // Reset, active low
   input  wire logic        irq_req,   // Request from the block
   input  wire logic [15:0] irq_vector, // Vector from the block
   input  wire logic        ack_en,    // Bench lets the CPU accept
   input  wire logic [3:0]  ack_dly,   // Cycles to wait before accepting
   output logic             irq_ack,   // Accept pulse, one cycle
   output logic      [15:0] last_vec,  // Vector seen at the accept edge
   output logic      [7:0]  n_ack      // Accepts made so far
);
   // accept pulse clears enable
   // Vector is taken at the edge that samples the accept; one process owns the outputs
   initial begin
      irq_ack  = 1'b0;
      last_vec = 16'h0000;
      n_ack    = 8'h00;
      forever begin
         @(posedge clk);
         if (rst_b === 1'b1 && ack_en === 1'b1 && irq_req === 1'b1) begin
            repeat (ack_dly) @(posedge clk);
            #1 irq_ack = 1'b1;
            @(posedge clk);
            last_vec = irq_vector;
            n_ack    = n_ack + 8'h01;
            #1 irq_ack = 1'b0;
         end
      end
   end
endmodule

// [tb/irq_control_and_power_modes_bench.sv]
// Purpose: Self-checking bench for the interrupt and power mode block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Reads are combinational and checked 2 ns after an edge
`timescale 1ns/10ps
module irq_control_and_power_modes_bench
   import icp_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, ext_irq_in_0 = 1'b1, ext_irq_in_1 = 1'b1;
   logic timer1_ovf = 1'b0, timer2_ovf = 1'b0, timer3_ovf = 1'b0, capture_en = 1'b0;
   logic capture_rise = 1'b0, event_count_input = 1'b0, serial_done = 1'b0;
   logic serial_susp = 1'b0, nib_wr = 1'b0, irq_ack, return_from_irq_instr = 1'b0;
   logic standby_instr = 1'b0, stop_instr = 1'b0, stop_cancel_input = 1'b0;
   logic        ack_en = 1'b0, irq_req, cpu_halt, osc_stop, periph_reset;
   logic        comparator_stop, pin_out_en, ram_valid_flag;
   logic [1:0]  nib_addr = 2'h0;
   logic [3:0]  nib_wdata = 4'h0, nib_rdata, ack_dly = 4'h3;
   logic [15:0] irq_vector, last_vec;
   logic [7:0]  n_ack, acks0;
   int          n_mismatch = 0, samples_checked = 0, i;
   logic [1:0]  ca [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
   logic [3:0]  cd [6] = '{4'h0, 4'h4, 4'h0, 4'h0, 4'h4, 4'h0};
   logic [15:0] cv [6] = '{16'h0004, 16'h0006, 16'h000A, 16'h000C, 16'h000E, 16'h0000};

   // Free running clock, 100 MHz
   always #5 clk = ~clk;

   icp_irq_power dut (.clk(clk), .rst_b(rst_b), .ext_irq_in_0(ext_irq_in_0),
      .ext_irq_in_1(ext_irq_in_1), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
      .timer3_ovf(timer3_ovf), .capture_en(capture_en), .capture_rise(capture_rise),
      .event_count_input(event_count_input), .serial_done(serial_done),
      .serial_susp(serial_susp), .nib_addr(nib_addr), .nib_wr(nib_wr),
      .nib_wdata(nib_wdata), .nib_rdata(nib_rdata), .irq_ack(irq_ack),
      .return_from_irq_instr(return_from_irq_instr), .standby_instr(standby_instr),
      .stop_instr(stop_instr), .stop_cancel_input(stop_cancel_input), .irq_req(irq_req),
      .irq_vector(irq_vector), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
      .periph_reset(periph_reset), .comparator_stop(comparator_stop),
      .pin_out_en(pin_out_en), .ram_valid_flag(ram_valid_flag));

   icp_cpu_model cpu (.clk(clk), .rst_b(rst_b), .irq_req(irq_req), .irq_vector(irq_vector),
      .ack_en(ack_en), .ack_dly(ack_dly), .irq_ack(irq_ack), .last_vec(last_vec),
      .n_ack(n_ack));

   // Compare a flag, a level or a vector
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Compare the addressed nibble
   task automatic rd(input logic [1:0] a, input logic [3:0] exp);
      @(posedge clk);
      #1 nib_addr = a;
      #1 chk({12'h000, nib_rdata}, {12'h000, exp});
   endtask
   task automatic wr(input logic [1:0] a, input logic [3:0] d);
      @(posedge clk);
      #1 {nib_wr, nib_addr, nib_wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 nib_wr = 1'b0;
   endtask
   // One-cycle events; bits: ext0 ext1 t1 t2 t3 done susp return standby stop
   task automatic ev(input logic [9:0] m);
      @(posedge clk);
      #1 {stop_instr, standby_instr, return_from_irq_instr, serial_susp, serial_done,
          timer3_ovf, timer2_ovf, timer1_ovf} = m[9:2];
      {ext_irq_in_1, ext_irq_in_0} = ~m[1:0];
      @(posedge clk);
      #1 {stop_instr, standby_instr, return_from_irq_instr, serial_susp, serial_done,
          timer3_ovf, timer2_ovf, timer1_ovf} = 8'h00;
      {ext_irq_in_1, ext_irq_in_0} = 2'b11;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic lev(input logic v);
      @(posedge clk);
      #1 event_count_input = v;
      repeat (3) @(posedge clk);
   endtask
   // Accept through the CPU model, bounded wait
   task automatic take(input logic [9:0] m, input logic [15:0] vec);
      acks0  = n_ack;
      ack_en = 1'b1;
      ev(m);
      for (i = 0; i < 20 && n_ack === acks0; i++) @(posedge clk);
      #1 ack_en = 1'b0;
      // A run-out wait leaves the accept count unchanged and counts as a mismatch
      chk({8'h00, n_ack}, {8'h00, acks0 + 8'h01});
      chk(last_vec, vec);
   endtask
   task automatic close_out;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog, far beyond the fewer than two hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      close_out;
   end

   initial begin
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      rd(0, 4'h4); rd(1, 4'hA); rd(2, 4'h8); rd(3, 4'hA);
      wr(0, 4'hF); wr(1, 4'hF); wr(2, 4'hF); wr(3, 4'hF);
      rd(0, 4'h5); rd(1, 4'hA); rd(2, 4'h8); rd(3, 4'hA);
      wr(0, 4'h0); wr(1, 4'h0); wr(2, 4'h0); wr(3, 4'h0);
      ev(10'h07F);
      rd(0, 4'h2); rd(1, 4'h5); rd(2, 4'h4); rd(3, 4'h5);
      chk(irq_req, 1'b0);
      chk(irq_vector, ICP_VEC_EXT0);
      wr(0, 4'h6);
      chk(irq_vector, ICP_VEC_EXT1);
      wr(1, 4'hF);
      chk(irq_vector, ICP_VEC_TMR2);
      wr(2, 4'hC); chk(irq_vector, ICP_VEC_TMR3);
      wr(3, 4'h7); chk(irq_vector, ICP_VEC_SER);
      wr(3, 4'hF); chk(irq_vector, ICP_VEC_NONE);
      wr(2, 4'h4); wr(3, 4'h5);
      wr(1, 4'h5); wr(0, 4'h3);
      chk(irq_req, 1'b1);
      wr(0, 4'h2);
      // Drain the sources from the highest down
      for (int k = 0; k < 6; k++) begin
         wr(ca[k], cd[k]);
         chk(irq_vector, cv[k]);
      end
      // Slow accept, then return, then a prompt accept
      wr(0, 4'h1);
      take(10'h008, ICP_VEC_TMR2);
      rd(0, 4'h0);
      wr(2, 4'h0);
      ev(10'h080);
      rd(0, 4'h1);
      ack_dly = 4'h0;
      take(10'h020, ICP_VEC_SER);
      rd(0, 4'h0); rd(3, 4'h4);
      wr(3, 4'h0);
      // Set and clear land on the same edge
      @(posedge clk);
      #1 {timer1_ovf, nib_wr, nib_addr, nib_wdata} = {1'b1, 1'b1, 2'h1, 4'h0};
      @(posedge clk);
      #1 {timer1_ovf, nib_wr} = 2'b00;
      rd(1, 4'h4);
      wr(1, 4'h0);
      // Capture edge selection
      capture_en = 1'b1; capture_rise = 1'b1;
      lev(1'b1); rd(3, 4'h1);
      wr(3, 4'h0); capture_rise = 1'b0;
      lev(1'b0); rd(3, 4'h1);
      wr(3, 4'h0);
      lev(1'b1); rd(3, 4'h0);
      capture_en = 1'b0;
      lev(1'b0); rd(3, 4'h0);
      // Standby refused while a request is pending, then woken by a request
      ev(10'h010); ev(10'h100);
      chk(cpu_halt, 1'b0);
      wr(3, 4'h0); ev(10'h100);
      chk({cpu_halt, comparator_stop, osc_stop, periph_reset}, 4'hC);
      ev(10'h040);
      chk(cpu_halt, 1'b0);
      wr(3, 4'h0);
      // Cancel outside stop is ignored; stop, then cancel
      @(posedge clk);
      #1 stop_cancel_input = 1'b1;
      @(posedge clk);
      #1 stop_cancel_input = 1'b0;
      @(posedge clk);
      #1 chk(ram_valid_flag, 1'b0);
      ev(10'h200);
      chk({osc_stop, periph_reset, pin_out_en}, 3'b110);
      stop_cancel_input = 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({osc_stop, pin_out_en, ram_valid_flag}, 3'b011);
      stop_cancel_input = 1'b0;
      // Reset in mid-run
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(ram_valid_flag, 1'b0);
      rst_b = 1'b1;
      rd(1, 4'hA);
      close_out;
   end
endmodule
